// >>> src/pdh_pkg.sv
// What this block does
// (R1) Host initialises each device after power-on
// (R2) Host reaches each device's control registers separately
// (R3) Palette writes may go to all devices; here each host reaches only its one device
// (R4) Select 00 pointer low, 01 pointer high
// (R5) Select 10 indirect, 11 main palette
// (R6) Pointer 0x0201..0x0203 select command registers 0-2
// (R7) Low 04-07 select pixel read/blink masks
// (R8) Low 08/09 select overlay read/blink masks
// (R9) Main palette 000-3FF, red green blue per entry
// (R10) High 00 reaches alternate palette 00-FF
// (R11) High 01 reaches overlay palette 00-1F
// (R12) Command register 2 D0/E0/F0 picks channel
// (R13) Command 0 gets 40, command 1 gets 00
// (R14) Read mask low FF, blink/overlay masks zero
// (R15) Pointer write restarts red-green-blue sequence
package pdh_pkg;
  // Pin timing, converted to whole mclk_i cycles (4 ns).
  localparam int CLK_PERIOD_NS = 4;
  localparam int CE_LOW_NS = 75;
  localparam int CE_HIGH_NS = 25;
  localparam int CE_LOW_CYC = (CE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_HIGH_CYC = (CE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register select codes.
  localparam logic [1:0] SEL_PTR_LO = 2'h0;
  localparam logic [1:0] SEL_PTR_HI = 2'h1;
  localparam logic [1:0] SEL_INDIRECT = 2'h2;
  localparam logic [1:0] SEL_MAIN = 2'h3;
  // Pointer high byte meanings for indirect accesses.
  localparam logic [7:0] PTR_HI_ALT = 8'h00;
  localparam logic [7:0] PTR_HI_OVL = 8'h01;
  localparam logic [7:0] PTR_HI_CTRL = 8'h02;
  // Control registers sit at pointer low 01..09, stored at index low-1.
  localparam logic [7:0] CTRL_LO_FIRST = 8'h01;
  localparam logic [7:0] CTRL_LO_LAST = 8'h09;
  localparam int CTRL_NUM = 9;
  localparam int IDX_CMD0 = 0;
  localparam int IDX_CMD1 = 1;
  localparam int IDX_CMD2 = 2;
  localparam int IDX_PRM_LO = 3;
  localparam int IDX_PRM_HI = 4;
  localparam int IDX_PBM_LO = 5;
  localparam int IDX_PBM_HI = 6;
  localparam int IDX_ORM = 7;
  localparam int IDX_OBM = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Palette depths and colour phases.
  localparam int MAIN_DEPTH = 1024;
  localparam int ALT_DEPTH = 256;
  localparam int OVL_DEPTH = 32;
  localparam logic [1:0] PHASE_BLUE = 2'h2;
  // Initialisation values.
  localparam logic [7:0] INIT_CMD0 = 8'h40;
  localparam logic [7:0] INIT_CMD1 = 8'h00;
  localparam logic [7:0] INIT_CMD2_RED = 8'hd0;
  localparam logic [7:0] INIT_CMD2_GREEN = 8'he0;
  localparam logic [7:0] INIT_CMD2_BLUE = 8'hf0;
  localparam logic [7:0] INIT_PRM_LO = 8'hff;
  localparam logic [7:0] INIT_PRM_HI = 8'h03;
  localparam logic [7:0] INIT_ZERO = 8'h00;
  // Host register map, Avalon word addresses.
  localparam logic [1:0] AV_CMD = 2'h0;
  localparam logic [1:0] AV_STATUS = 2'h1;
  localparam logic [1:0] AV_RDATA = 2'h2;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_SEL_LSB = 8;
  localparam int CMD_READ_BIT = 10;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_INIT_BIT = 1;

  // What a pin access reaches inside the device.
  typedef enum logic [2:0] {
    TGT_PTR_LO, TGT_PTR_HI, TGT_CTRL, TGT_ALT, TGT_OVL, TGT_MAIN, TGT_NONE
  } pdh_tgt_e;
endpackage : pdh_pkg

// >>> src/pdh_bus_if.sv
`timescale 1ns/100ps
// Shared 8-bit processor bus between one host end and one device end.
interface pdh_bus_if;
  logic ce_n;
  logic rd_wr;
  logic reg_select_hi;
  logic reg_select_lo;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic [7:0] data;

  // Resolved bus level; an undriven bus floats high.
  assign data = host_data_oe ? host_data : (dev_data_oe ? dev_data : 8'hff);

  modport host (
    output ce_n, rd_wr, reg_select_hi, reg_select_lo, host_data, host_data_oe,
    input data
  );
  modport device (
    input ce_n, rd_wr, reg_select_hi, reg_select_lo, data,
    output dev_data, dev_data_oe
  );
endinterface : pdh_bus_if

// >>> src/pdh_device.sv
`timescale 1ns/100ps
module pdh_device
  import pdh_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Processor bus.
  pdh_bus_if.device bus,
  // Pixel side lookup.
  input wire logic [9:0] pix_addr_i,
  output logic [23:0] pix_rgb_o,
  // Control register and pointer contents.
  output logic [CTRL_NUM-1:0][7:0] ctrl_o,
  output logic [15:0] ptr_o
);

  typedef struct packed {
    logic ce_m;
    logic ce_s;
    logic ce_p;
    logic rd_m;
    logic rd_s;
    logic [1:0] sel_m;
    logic [1:0] sel_s;
    logic [7:0] dat_m;
    logic [7:0] dat_s;
    logic [15:0] ptr;
    logic [1:0] phase;
    logic [CTRL_NUM-1:0][7:0] ctrl;
    logic [7:0] rd_data;
    logic [23:0] pix_rgb;
  } pdh_dev_s;

  pdh_dev_s st_ff;
  pdh_dev_s nxt_st;

  // Palettes; each entry packs red, green and blue from high byte down.
  logic [23:0] main_mem [MAIN_DEPTH];
  logic [23:0] alt_mem [ALT_DEPTH];
  logic [23:0] ovl_mem [OVL_DEPTH];

  logic ce_fall;
  logic ce_rise;
  pdh_tgt_e tgt;
  logic main_we;
  logic alt_we;
  logic ovl_we;
  logic [4:0] lane_lsb;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of select code and pointer into an access target.
  function automatic pdh_tgt_e decode(input logic [1:0] sel, input logic [15:0] ptr);
    pdh_tgt_e t;
    t = TGT_NONE;
    unique case (sel)
      SEL_PTR_LO: t = TGT_PTR_LO; // [R4]
      SEL_PTR_HI: t = TGT_PTR_HI; // [R4]
      SEL_MAIN: t = TGT_MAIN; // [R5] [R9]
      SEL_INDIRECT: begin // [R5]
        if (ptr[15:8] == PTR_HI_CTRL && ptr[7:0] >= CTRL_LO_FIRST
            && ptr[7:0] <= CTRL_LO_LAST) begin
          t = TGT_CTRL; // [R6] [R7] [R8]
        end else if (ptr[15:8] == PTR_HI_ALT) begin
          t = TGT_ALT; // [R10]
        end else if (ptr[15:8] == PTR_HI_OVL && ptr[7:5] == 3'h0) begin
          t = TGT_OVL; // [R11]
        end
      end
    endcase
    return t;
  endfunction : decode

  // Byte of an entry that the colour phase picks: red, then green, then blue.
  function automatic logic [7:0] pick(input logic [23:0] entry, input logic [1:0] phase);
    logic [7:0] b;
    b = entry[23:16];
    if (phase == 2'h1) begin
      b = entry[15:8];
    end else if (phase == PHASE_BLUE) begin
      b = entry[7:0];
    end
    return b;
  endfunction : pick

  ////////////////////////////////////////////////////////////////////////////
  // Strobe edges, taken only from the second synchroniser stage onward.
  assign ce_fall = st_ff.ce_p & ~st_ff.ce_s;
  assign ce_rise = ~st_ff.ce_p & st_ff.ce_s;
  assign tgt = decode(st_ff.sel_s, st_ff.ptr);
  assign lane_lsb = 5'(16 - 8 * st_ff.phase);

  // Palette writes land when the strobe is released, so data is settled.
  always_comb begin
    main_we = ce_rise & ~st_ff.rd_s & (tgt == TGT_MAIN); // [R9]
    alt_we = ce_rise & ~st_ff.rd_s & (tgt == TGT_ALT); // [R10]
    ovl_we = ce_rise & ~st_ff.rd_s & (tgt == TGT_OVL); // [R11]
  end

  // Next state: synchronisers, pointer, colour phase, control and read data.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ce_m = bus.ce_n;
    nxt_st.ce_s = st_ff.ce_m;
    nxt_st.ce_p = st_ff.ce_s;
    nxt_st.rd_m = bus.rd_wr;
    nxt_st.rd_s = st_ff.rd_m;
    nxt_st.sel_m = {bus.reg_select_hi, bus.reg_select_lo};
    nxt_st.sel_s = st_ff.sel_m;
    nxt_st.dat_m = bus.data;
    nxt_st.dat_s = st_ff.dat_m;
    nxt_st.pix_rgb = main_mem[pix_addr_i];
    // Read data is fetched when the strobe falls and held for the access.
    if (ce_fall && st_ff.rd_s) begin
      unique case (tgt)
        TGT_PTR_LO: nxt_st.rd_data = st_ff.ptr[7:0];
        TGT_PTR_HI: nxt_st.rd_data = st_ff.ptr[15:8];
        TGT_CTRL: nxt_st.rd_data = st_ff.ctrl[st_ff.ptr[3:0] - 4'h1];
        TGT_ALT: nxt_st.rd_data = pick(alt_mem[st_ff.ptr[7:0]], st_ff.phase);
        TGT_OVL: nxt_st.rd_data = pick(ovl_mem[st_ff.ptr[4:0]], st_ff.phase);
        TGT_MAIN: nxt_st.rd_data = pick(main_mem[st_ff.ptr[9:0]], st_ff.phase);
        TGT_NONE: nxt_st.rd_data = 8'h00;
      endcase
    end
    if (ce_rise) begin
      unique case (tgt)
        TGT_PTR_LO: begin
          if (!st_ff.rd_s) begin
            nxt_st.ptr[7:0] = st_ff.dat_s; // [R4]
            nxt_st.phase = 2'h0; // [R15]
          end
        end
        TGT_PTR_HI: begin
          if (!st_ff.rd_s) begin
            nxt_st.ptr[15:8] = st_ff.dat_s; // [R4]
            nxt_st.phase = 2'h0; // [R15]
          end
        end
        TGT_CTRL: begin
          if (!st_ff.rd_s) begin
            nxt_st.ctrl[st_ff.ptr[3:0] - 4'h1] = st_ff.dat_s; // [R6] [R7] [R8]
          end
        end
        TGT_ALT, TGT_OVL, TGT_MAIN: begin
          // Blue closes an entry; the pointer then steps within its palette.
          if (st_ff.phase == PHASE_BLUE) begin
            nxt_st.phase = 2'h0;
            if (tgt == TGT_MAIN) begin
              nxt_st.ptr = {6'h00, st_ff.ptr[9:0] + 10'h001}; // [R9]
            end else if (tgt == TGT_ALT) begin
              nxt_st.ptr[7:0] = st_ff.ptr[7:0] + 8'h01; // [R10]
            end else begin
              nxt_st.ptr[7:0] = {3'h0, st_ff.ptr[4:0] + 5'h01}; // [R11]
            end
          end else begin
            nxt_st.phase = st_ff.phase + 2'h1; // [R9] [R10] [R11]
          end
        end
        TGT_NONE: nxt_st.phase = st_ff.phase;
      endcase
    end
  end

  // Control state register; the bus idles with the strobe high.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.ce_m <= 1'b1;
      st_ff.ce_s <= 1'b1;
      st_ff.ce_p <= 1'b1;
      st_ff.ctrl <= {CTRL_NUM{CTRL_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Palette memories carry no reset; software must fill them first.
  always_ff @(posedge mclk_i) begin
    if (main_we) begin
      main_mem[st_ff.ptr[9:0]][lane_lsb +: 8] <= st_ff.dat_s;
    end
    if (alt_we) begin
      alt_mem[st_ff.ptr[7:0]][lane_lsb +: 8] <= st_ff.dat_s;
    end
    if (ovl_we) begin
      ovl_mem[st_ff.ptr[4:0]][lane_lsb +: 8] <= st_ff.dat_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The device drives the bus only during a read, once the strobe is seen low.
  assign bus.dev_data = st_ff.rd_data;
  assign bus.dev_data_oe = ~st_ff.ce_s & ~st_ff.ce_p & st_ff.rd_s;
  assign pix_rgb_o = st_ff.pix_rgb;
  assign ctrl_o = st_ff.ctrl;
  assign ptr_o = st_ff.ptr;

endmodule : pdh_device

// >>> src/pdh_host.sv
`timescale 1ns/100ps
module pdh_host
  import pdh_pkg::*;
#(
  parameter logic [1:0] CHANNEL = 2'h0 // 0 red, 1 green, 2 blue.
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Processor bus to one device.
  pdh_bus_if.host bus
);

  // Only three colour channels exist, so anything else is refused at elaboration.
  if (CHANNEL > 2'h2) begin : g_bad_channel
    $error("CHANNEL must be 0, 1 or 2");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH} pdh_st_e;

  typedef struct packed {
    pdh_st_e state;
    logic [7:0] cnt;
    logic ce_n;
    logic rd;
    logic [1:0] sel;
    logic [7:0] wdata;
    logic doe;
    logic [7:0] din_m;
    logic [7:0] din_s;
    logic [7:0] rdata;
    logic [4:0] init_step;
    logic init_done;
    logic rd_ack;
    logic [31:0] readdata;
  } pdh_host_s;

  pdh_host_s st_ff;
  pdh_host_s nxt_st;
  logic cmd_wr;
  logic busy;
  logic [1:0] init_sel;
  logic [7:0] init_data;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Initialisation script for one device: pointer high, then per register
  // a pointer low write followed by its value.
  function automatic logic [7:0] init_value(input logic [3:0] idx, input logic [1:0] chan);
    logic [7:0] v;
    v = INIT_ZERO; // [R14]
    unique case (idx)
      4'(IDX_CMD0): v = INIT_CMD0; // [R13]
      4'(IDX_CMD1): v = INIT_CMD1; // [R13]
      4'(IDX_CMD2): v = (chan == 2'h0) ? INIT_CMD2_RED :
                        ((chan == 2'h1) ? INIT_CMD2_GREEN : INIT_CMD2_BLUE); // [R12]
      4'(IDX_PRM_LO): v = INIT_PRM_LO; // [R14]
      4'(IDX_PRM_HI): v = INIT_PRM_HI;
      default: v = INIT_ZERO; // [R14]
    endcase
    return v;
  endfunction : init_value

  always_comb begin
    logic [3:0] idx;
    idx = 4'(({1'b0, st_ff.init_step} - 6'h1) >> 1);
    if (st_ff.init_step == 5'h0) begin
      init_sel = SEL_PTR_HI;
      init_data = PTR_HI_CTRL;
    end else if (st_ff.init_step[0]) begin
      init_sel = SEL_PTR_LO;
      init_data = CTRL_LO_FIRST + 8'(idx);
    end else begin
      init_sel = SEL_INDIRECT;
      init_data = init_value(idx, CHANNEL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon side: command writes stall while a pin access runs; reads take
  // one wait cycle so that read data comes from a register.
  assign busy = (st_ff.state != ST_IDLE) | ~st_ff.init_done;
  assign cmd_wr = avs_write_i & (avs_address_i == AV_CMD);
  assign avs_waitrequest_o = (avs_read_i & ~st_ff.rd_ack) | (cmd_wr & busy);
  assign avs_readdata_o = st_ff.readdata;

  always_comb begin
    rd_word = 32'h0;
    unique case (avs_address_i)
      AV_CMD: rd_word = {21'h0, st_ff.rd, st_ff.sel, st_ff.wdata};
      AV_STATUS: rd_word = {30'h0, st_ff.init_done, busy};
      AV_RDATA: rd_word = {24'h0, st_ff.rdata};
      default: rd_word = 32'h0;
    endcase
  end

  // Next state of the pin sequencer and the register side.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.din_m = bus.data;
    nxt_st.din_s = st_ff.din_m;
    nxt_st.rd_ack = avs_read_i & ~st_ff.rd_ack;
    if (avs_read_i && !st_ff.rd_ack) begin
      nxt_st.readdata = rd_word;
    end
    unique case (st_ff.state)
      ST_IDLE: begin
        if (!st_ff.init_done) begin
          // This host's one device is set up before software gets the bus. [R1]
          nxt_st.rd = 1'b0;
          nxt_st.sel = init_sel;
          nxt_st.wdata = init_data;
          nxt_st.doe = 1'b1;
          nxt_st.state = ST_SETUP;
        end else if (cmd_wr) begin
          nxt_st.rd = avs_writedata_i[CMD_READ_BIT];
          nxt_st.sel = avs_writedata_i[CMD_SEL_LSB +: 2];
          nxt_st.wdata = avs_writedata_i[CMD_DATA_LSB +: 8];
          nxt_st.doe = ~avs_writedata_i[CMD_READ_BIT];
          nxt_st.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        nxt_st.ce_n = 1'b0;
        nxt_st.cnt = 8'(CE_LOW_CYC - 1);
        nxt_st.state = ST_LOW;
      end
      ST_LOW: begin
        if (st_ff.cnt == 8'h0) begin
          nxt_st.ce_n = 1'b1;
          nxt_st.cnt = 8'(CE_HIGH_CYC - 1);
          nxt_st.state = ST_HIGH;
          if (st_ff.rd) begin
            nxt_st.rdata = st_ff.din_s;
          end
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h1;
        end
      end
      ST_HIGH: begin
        // Select and data are held through the recovery time.
        if (st_ff.cnt == 8'h0) begin
          nxt_st.doe = 1'b0;
          nxt_st.state = ST_IDLE;
          if (!st_ff.init_done) begin
            nxt_st.init_step = st_ff.init_step + 5'h1;
            nxt_st.init_done = (st_ff.init_step == 5'(2 * CTRL_NUM));
          end
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.ce_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Each host end owns one device's strobe, so control accesses stay
  // per device; palette writes likewise reach only that one device. [R2] [R3]
  assign bus.ce_n = st_ff.ce_n;
  assign bus.rd_wr = st_ff.rd;
  assign bus.reg_select_hi = st_ff.sel[1];
  assign bus.reg_select_lo = st_ff.sel[0];
  assign bus.host_data = st_ff.wdata;
  assign bus.host_data_oe = st_ff.doe;

endmodule : pdh_host

// >>> testbench/pdh_chk.sv
`timescale 1ns/100ps
module pdh_chk
  import pdh_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Bus lines.
  input wire logic ce_n,
  input wire logic rd_wr,
  input wire logic reg_select_hi,
  input wire logic reg_select_lo,
  input wire logic [7:0] host_data,
  input wire logic host_data_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  // Counts strobe-low cycles; the strobe is longer than a repetition may unroll.
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  always_comb begin
    nxt_low_cnt = ce_n ? 8'h00 : low_cnt_ff + 8'h01;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_ff <= 8'h00;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end
  ////////////////////////////////////////
  // Write cycle steps: strobe falls on a driven bus, then a held release phase.
  sequence s_wr_start;
    $fell(ce_n) && !rd_wr;
  endsequence
  sequence s_release;
    (ce_n && host_data_oe)[*7] ##1 !host_data_oe;
  endsequence
  property p_ce_low_len;
    $rose(ce_n) |-> low_cnt_ff == 8'(CE_LOW_CYC);
  endproperty
  property p_wr_setup;
    s_wr_start |-> $past(host_data_oe) && host_data_oe;
  endproperty
  property p_wr_release;
    $rose(ce_n) && !rd_wr |-> s_release;
  endproperty
  property p_ctl_stable;
    !ce_n && !$fell(ce_n) |-> $stable({rd_wr, reg_select_hi, reg_select_lo, host_data});
  endproperty
  property p_no_clash;
    !(host_data_oe && dev_data_oe);
  endproperty
  property p_rd_drive;
    $fell(ce_n) && rd_wr |-> !dev_data_oe ##[2:6] dev_data_oe;
  endproperty
  property p_rd_release;
    $rose(ce_n) |-> ##[1:4] !dev_data_oe;
  endproperty
  property p_wr_quiet;
    !ce_n && !rd_wr |-> !dev_data_oe;
  endproperty
  a_ce_low_len: assert property (p_ce_low_len)
    else $error("strobe low time wrong");
  a_wr_setup: assert property (p_wr_setup)
    else $error("write data not driven before strobe");
  a_wr_release: assert property (p_wr_release)
    else $error("write release phase wrong");
  a_ctl_stable: assert property (p_ctl_stable)
    else $error("select or data moved during strobe");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the bus");
  a_rd_drive: assert property (p_rd_drive)
    else $error("device did not drive read data");
  a_rd_release: assert property (p_rd_release)
    else $error("device kept the bus after strobe");
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("device drove bus in a write");
endmodule : pdh_chk

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import pdh_pkg::*;
  logic mclk_i, rst_n_i, avs_read, avs_write, avs_waitrequest;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, s;
  logic [9:0] pix_addr;
  logic [23:0] pix_rgb;
  logic [CTRL_NUM-1:0][7:0] ctrl;
  logic [15:0] ptr;
  logic [7:0] b;
  logic [7:0] exp_ctrl [CTRL_NUM] = '{INIT_CMD0, INIT_CMD1, INIT_CMD2_RED, INIT_PRM_LO,
    INIT_PRM_HI, INIT_ZERO, INIT_ZERO, INIT_ZERO, INIT_ZERO};
  int err_total, check_count, i, k;
  pdh_bus_if pdh_bus_if_inst();
  pdh_host #(.CHANNEL(2'h0)) pdh_host_inst(.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .bus(pdh_bus_if_inst));
  pdh_device pdh_device_inst(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(pdh_bus_if_inst),
    .pix_addr_i(pix_addr), .pix_rgb_o(pix_rgb), .ctrl_o(ctrl), .ptr_o(ptr));
  pdh_chk pdh_chk_inst(.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_n(pdh_bus_if_inst.ce_n),
    .rd_wr(pdh_bus_if_inst.rd_wr), .reg_select_hi(pdh_bus_if_inst.reg_select_hi),
    .reg_select_lo(pdh_bus_if_inst.reg_select_lo), .host_data(pdh_bus_if_inst.host_data),
    .host_data_oe(pdh_bus_if_inst.host_data_oe), .dev_data_oe(pdh_bus_if_inst.dev_data_oe));
  ////////////////////////////////////////
  // Free-running clock at 250 MHz.
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One Avalon transfer; the request stands until an edge sees waitrequest low, and
  // read data is taken at that same edge, before the slave's registers move on.
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge mclk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge mclk_i);
    while (avs_waitrequest !== 1'b0) @(posedge mclk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  // One pin access, then wait until the sequencer reports idle.
  task automatic pin(input logic [1:0] sel, input logic [7:0] d, input logic rd);
    logic [31:0] r;
    int n;
    av(1'b1, AV_CMD, {21'h0, rd, sel, d}, r);
    n = 0;
    do begin
      av(1'b0, AV_STATUS, 32'h0, r);
      n++;
    end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 100);
    chk("busy", 32'h0, {31'h0, r[STAT_BUSY_BIT]});
  endtask : pin
  task automatic rd_byte(input logic [1:0] sel, output logic [7:0] v);
    logic [31:0] r;
    pin(sel, 8'h00, 1'b1);
    av(1'b0, AV_RDATA, 32'h0, r);
    v = r[7:0];
  endtask : rd_byte
  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    pin(SEL_PTR_LO, lo, 1'b0);
    pin(SEL_PTR_HI, hi, 1'b0);
  endtask : set_ptr
  task automatic pix(input logic [9:0] a, input logic [23:0] exp);
    @(posedge mclk_i);
    pix_addr <= a;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("pix_rgb", {8'h0, exp}, {8'h0, pix_rgb});
  endtask : pix
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////
  // Watchdog sized well above the few thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    $display("BAD watchdog expected done seen hang");
    results();
  end
  initial begin
    rst_n_i = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 2'h0;
    avs_writedata = 32'h0;
    pix_addr = 10'h0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    k = 0;
    do begin
      av(1'b0, AV_STATUS, 32'h0, s);
      k++;
    end while (s[STAT_INIT_BIT] !== 1'b1 && k < 1000);
    chk("init_done", 32'h1, {31'h0, s[STAT_INIT_BIT]});
    for (i = 0; i < CTRL_NUM; i++) begin
      chk("ctrl", {24'h0, exp_ctrl[i]}, {24'h0, ctrl[i]});
    end
    chk("ptr", 32'h0209, {16'h0, ptr});
    av(1'b1, 2'h3, 32'hffffffff, s);
    av(1'b0, 2'h3, 32'h0, s);
    chk("unmapped", 32'h0, s);
    $display("test init done");
    // Control registers: write one, read all nine back through the pointer.
    set_ptr(8'h02, 8'h01);
    chk("ptr", 32'h0201, {16'h0, ptr});
    rd_byte(SEL_PTR_LO, b);
    chk("ptr_lo_rd", 32'h01, {24'h0, b});
    rd_byte(SEL_PTR_HI, b);
    chk("ptr_hi_rd", 32'(PTR_HI_CTRL), {24'h0, b});
    pin(SEL_INDIRECT, 8'h5a, 1'b0);
    exp_ctrl[0] = 8'h5a;
    chk("cmd0", 32'h5a, {24'h0, ctrl[0]});
    for (i = 0; i < CTRL_NUM; i++) begin
      pin(SEL_PTR_LO, 8'(i + 1), 1'b0);
      rd_byte(SEL_INDIRECT, b);
      chk("ctrl_rd", {24'h0, exp_ctrl[i]}, {24'h0, b});
    end
    // Pointer 0x0200 decodes to nothing: the write is dropped and a read gives zero.
    set_ptr(PTR_HI_CTRL, 8'h00);
    pin(SEL_INDIRECT, 8'h77, 1'b0);
    rd_byte(SEL_INDIRECT, b);
    chk("none_rd", 32'h0, {24'h0, b});
    chk("none_ptr", 32'h0200, {16'h0, ptr});
    chk("none_ctrl", {24'h0, exp_ctrl[0]}, {24'h0, ctrl[0]});
    $display("test control done");
    // Main palette: two entries, a restarted entry, then the top entry wraps.
    set_ptr(8'h00, 8'h00);
    for (i = 0; i < 6; i++) pin(SEL_MAIN, 8'(8'h11 + i), 1'b0);
    pix(10'h000, 24'h111213);
    pix(10'h001, 24'h141516);
    chk("ptr", 32'h0002, {16'h0, ptr});
    pin(SEL_MAIN, 8'ha1, 1'b0);
    pin(SEL_MAIN, 8'ha2, 1'b0);
    pin(SEL_PTR_LO, 8'h02, 1'b0);
    for (i = 0; i < 3; i++) pin(SEL_MAIN, 8'(8'hc1 + i), 1'b0);
    pix(10'h002, 24'hc1c2c3);
    set_ptr(8'h03, 8'hff);
    for (i = 0; i < 3; i++) pin(SEL_MAIN, 8'(8'h31 + i), 1'b0);
    pix(10'h3ff, 24'h313233);
    chk("ptr", 32'h0000, {16'h0, ptr});
    // Reads walk the same red, green, blue order from a zeroed pointer.
    set_ptr(8'h00, 8'h00);
    for (i = 0; i < 3; i++) begin
      rd_byte(SEL_MAIN, b);
      chk("main_rd", 32'(8'h11 + i), {24'h0, b});
    end
    $display("test main done");
    // Alternate then overlay palette: last entry written, wrap seen, read back.
    for (k = 0; k < 2; k++) begin
      set_ptr(8'(k), k ? 8'h1f : 8'hff);
      for (i = 0; i < 3; i++) pin(SEL_INDIRECT, 8'(8'h60 + 16 * k + i), 1'b0);
      chk("ptr", 32'(k * 256), {16'h0, ptr});
      set_ptr(8'(k), k ? 8'h1f : 8'hff);
      for (i = 0; i < 3; i++) begin
        rd_byte(SEL_INDIRECT, b);
        chk("small_pal", 32'(8'h60 + 16 * k + i), {24'h0, b});
      end
    end
    $display("test small palettes done");
    results();
  end
endmodule : tb
